/* File: hdl/ppvs_pkg.sv */
// Purpose: shared constants and types for the program/verify sequencer
// Assumes: 50 MHz system clock
// Notes:   high-voltage pins are driven as level codes for an external driver
package ppvs_pkg;
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned STEP_US        = 4;
  localparam int unsigned PULSE_US       = 10;
  localparam int unsigned SEC_PULSE_US   = 300;
  localparam int unsigned VERIFY_US      = 10;
  localparam int unsigned RAMP_US        = 500;
  localparam int unsigned STEP_CYC       = STEP_US * CLK_MHZ;
  localparam int unsigned PULSE_CYC      = PULSE_US * CLK_MHZ;
  localparam int unsigned SEC_PULSE_CYC  = SEC_PULSE_US * CLK_MHZ;
  localparam int unsigned VERIFY_CYC     = VERIFY_US * CLK_MHZ;
  localparam int unsigned RAMP_CYC       = RAMP_US * CLK_MHZ;
  localparam int unsigned LINES_PER_GRP  = 32;
  localparam logic [3:0]  TGA_ZERO       = 4'h0;
  localparam logic [3:0]  TGA_GROUP0     = 4'h8;
  localparam logic [3:0]  TGA_OE         = 4'h9;
  localparam logic [3:0]  TGA_SIG        = 4'hA;
  localparam logic [7:0]  LINE_ZERO      = 8'h00;
  localparam logic [7:0]  LINE_ALL_ONES  = 8'hFF;

  // pin level codes
  typedef enum logic [2:0] {
    PPVS_LOW = 3'h0, PPVS_HIGH = 3'h1, PPVS_HV1 = 3'h2, PPVS_HV2 = 3'h3, PPVS_HV3 = 3'h4
  } ppvs_level_t;

  typedef enum logic [1:0] {
    PPVS_OP_VERIFY = 2'h0, PPVS_OP_ERASE = 2'h1, PPVS_OP_PROG = 2'h2, PPVS_OP_SECURE = 2'h3
  } ppvs_op_t;

  typedef struct packed {
    ppvs_level_t enable;
    ppvs_level_t pulse;
    ppvs_level_t latch;
    ppvs_level_t secod;
    logic        sel_a;
    logic        sel_b;
    logic [3:0]  tga;
  } ppvs_pins_t;
endpackage

/* File: hdl/ppvs_sequencer.sv */
// Purpose: programmer-side sequencer for verify, erase-all, program-all, security flows
// Assumes: pulse ramping is done by the external high-voltage driver during ramp step
// Notes:   every step lasts a timer period; pins are steady between steps
`timescale 1ns/1ps

module ppvs_sequencer #(
  parameter int unsigned STEP_CYCLES   = ppvs_pkg::STEP_CYC,
  parameter int unsigned PULSE_CYCLES  = ppvs_pkg::PULSE_CYC,
  parameter int unsigned SEC_CYCLES    = ppvs_pkg::SEC_PULSE_CYC,
  parameter int unsigned VERIFY_CYCLES = ppvs_pkg::VERIFY_CYC,
  parameter int unsigned RAMP_CYCLES   = ppvs_pkg::RAMP_CYC
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               start,
  input  wire ppvs_pkg::ppvs_op_t op,
  input  wire logic               follow_pulse,
  input  wire logic [3:0]         verify_groups,
  input  wire logic [7:0]         expected_byte,
  input  wire logic [7:0]         data_in,
  output logic [7:0]              data_out,
  output logic                    data_oe,
  output ppvs_pkg::ppvs_pins_t    pins,
  output logic                    busy,
  output logic                    done,
  output logic                    byte_valid,
  output logic [7:0]              byte_read,
  output logic                    byte_match,
  output logic [3:0]              byte_group,
  output logic [4:0]              byte_line
);
  // the step timer is 24 bits wide and a zero count would leave a step only one cycle long
  if (STEP_CYCLES < 1 || PULSE_CYCLES < 1 || SEC_CYCLES < 1 || VERIFY_CYCLES < 1 ||
      RAMP_CYCLES < 1 || STEP_CYCLES >= 2**24 || SEC_CYCLES >= 2**24 ||
      RAMP_CYCLES >= 2**24 || PULSE_CYCLES >= 2**24 || VERIFY_CYCLES >= 2**24) begin : g_bad_timing
    $error("ppvs_sequencer: timing parameter out of range");
  end

  typedef enum logic [13:0] {
    S_IDLE    = 14'h0001, S_OPEN   = 14'h0002, S_ADDR   = 14'h0004, S_ARM    = 14'h0008,
    S_LATCH   = 14'h0010, S_REL    = 14'h0020, S_PULSE  = 14'h0040, S_LDROP  = 14'h0080,
    S_ODROP   = 14'h0100, S_READ   = 14'h0200, S_PLOW   = 14'h0400, S_RAMP   = 14'h0800,
    S_CLOSE   = 14'h1000, S_END    = 14'h2000
  } ppvs_state_t;

  ppvs_state_t        state_reg;
  ppvs_pkg::ppvs_op_t op_reg;
  logic               follow_reg;
  logic [3:0]         ngrp_reg;
  logic [3:0]         grp_reg;
  logic [4:0]         line_reg;
  logic [23:0]        timer_reg;
  logic               tick;
  logic [7:0]         din_s1_reg;
  logic [7:0]         din_s2_reg;
  logic [23:0]        dwell;
  ppvs_state_t        state_next;
  logic [23:0]        pulse_min;
  logic [23:0]        hv_run_reg;

  assign tick = (timer_reg == 24'h000000);

  // two-stage synchroniser on the shared data pins
  always_ff @(posedge clk) begin
    din_s1_reg <= data_in;
    din_s2_reg <= din_s1_reg;
  end

  // the step entered at the next timer expiry
  always_comb begin
    state_next = S_IDLE;
    case (state_reg)
      S_OPEN:  state_next = S_ADDR;
      S_ADDR: begin
        if (op_reg == ppvs_pkg::PPVS_OP_PROG)
          state_next = S_PULSE;
        else if (op_reg == ppvs_pkg::PPVS_OP_SECURE)
          state_next = S_LATCH;
        else
          state_next = S_ARM;
      end
      S_ARM:   state_next = (op_reg == ppvs_pkg::PPVS_OP_VERIFY) ? S_LATCH : S_PULSE;
      S_LATCH: state_next = (op_reg == ppvs_pkg::PPVS_OP_VERIFY) ? S_REL : S_ARM;
      S_REL:   state_next = S_PULSE;
      S_PULSE: state_next = (op_reg == ppvs_pkg::PPVS_OP_VERIFY) ? S_LDROP : S_RAMP;
      S_LDROP: state_next = S_ODROP;
      S_ODROP: state_next = S_READ;
      S_READ:  state_next = S_PLOW;
      S_RAMP:  state_next = S_PLOW;
      S_PLOW: begin
        if (op_reg == ppvs_pkg::PPVS_OP_VERIFY &&
            (line_reg != 5'(ppvs_pkg::LINES_PER_GRP - 1) || grp_reg + 4'h1 < ngrp_reg))
          state_next = S_ADDR;
        else
          state_next = S_CLOSE;
      end
      S_CLOSE: state_next = S_END;
      default: state_next = S_IDLE;
    endcase
  end

  // the timer is loaded for the step being entered, so pulse steps get their own width
  always_comb begin
    dwell = 24'(STEP_CYCLES);
    if (state_next == S_PULSE) begin
      if (op_reg == ppvs_pkg::PPVS_OP_VERIFY)
        dwell = 24'(VERIFY_CYCLES);
      else if (op_reg == ppvs_pkg::PPVS_OP_SECURE)
        dwell = 24'(SEC_CYCLES);
      else
        dwell = 24'(PULSE_CYCLES);
    end else if (state_next == S_RAMP) begin
      dwell = 24'(RAMP_CYCLES);
    end
  end

  // group code for verify index n: 8h minus n, then OE and signature groups
  function automatic logic [3:0] grp_code(input logic [3:0] n);
    if (n < 4'h8)
      grp_code = ppvs_pkg::TGA_GROUP0 - n;
    else if (n == 4'h8)
      grp_code = ppvs_pkg::TGA_OE;
    else
      grp_code = ppvs_pkg::TGA_SIG;
  endfunction

  // sequence control; every transition except the start from S_IDLE waits on the step timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg  <= S_IDLE;
      op_reg     <= ppvs_pkg::PPVS_OP_VERIFY;
      follow_reg <= 1'b0;
      ngrp_reg   <= 4'h0;
      grp_reg    <= 4'h0;
      line_reg   <= 5'h00;
      timer_reg  <= 24'h000000;
    end else if (state_reg == S_IDLE) begin
      if (start) begin
        state_reg  <= S_OPEN;
        op_reg     <= op;
        follow_reg <= follow_pulse;
        ngrp_reg   <= (verify_groups > 4'hA) ? 4'hA : verify_groups;
        grp_reg    <= 4'h0;
        line_reg   <= 5'h00;
        timer_reg  <= 24'(STEP_CYCLES);
      end
    end else if (!tick) begin
      timer_reg <= timer_reg - 24'h000001;
    end else begin
      timer_reg <= dwell;
      state_reg <= state_next;
      if (state_reg == S_PLOW && op_reg == ppvs_pkg::PPVS_OP_VERIFY) begin
        if (line_reg != 5'(ppvs_pkg::LINES_PER_GRP - 1)) begin
          line_reg <= line_reg + 5'h01;
        end else begin
          line_reg <= 5'h00;
          grp_reg  <= grp_reg + 4'h1;
        end
      end
    end
  end
  // security latches its address in S_LATCH before S_ARM (S_PULSE when follow_pulse is set) raises the security pin

  // pin levels follow state and flow
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins     <= '{ppvs_pkg::PPVS_LOW, ppvs_pkg::PPVS_LOW, ppvs_pkg::PPVS_LOW,
                    ppvs_pkg::PPVS_LOW, 1'b0, 1'b0, 4'h0};
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      pins.enable <= (state_reg == S_IDLE || state_reg == S_END) ?
                     ppvs_pkg::PPVS_LOW : ppvs_pkg::PPVS_HV1;
      pins.sel_a  <= (op_reg == ppvs_pkg::PPVS_OP_VERIFY || op_reg == ppvs_pkg::PPVS_OP_SECURE);
      pins.sel_b  <= (op_reg != ppvs_pkg::PPVS_OP_VERIFY);
      pins.tga    <= (op_reg == ppvs_pkg::PPVS_OP_VERIFY) ? grp_code(grp_reg) : ppvs_pkg::TGA_ZERO;
      // shared pins are driven while the address is set up and latched, and through S_PULSE, S_RAMP and S_PLOW of non-verify flows
      data_oe     <= (state_reg == S_ADDR || state_reg == S_ARM || state_reg == S_LATCH ||
                      (op_reg != ppvs_pkg::PPVS_OP_VERIFY && state_reg inside
                       {S_PULSE, S_RAMP, S_PLOW}));
      case (op_reg)
        ppvs_pkg::PPVS_OP_VERIFY: data_out <= {3'h0, line_reg};
        ppvs_pkg::PPVS_OP_PROG:   data_out <= ppvs_pkg::LINE_ALL_ONES;
        default:                  data_out <= ppvs_pkg::LINE_ZERO;
      endcase
      pins.pulse <= ppvs_pkg::PPVS_LOW;
      if (state_reg inside {S_PULSE, S_LDROP, S_ODROP, S_READ})
        pins.pulse <= (op_reg == ppvs_pkg::PPVS_OP_VERIFY) ? ppvs_pkg::PPVS_HV2
                                                           : ppvs_pkg::PPVS_HV3;
      else if (state_reg == S_RAMP)
        pins.pulse <= ppvs_pkg::PPVS_HV2;
      pins.latch <= ppvs_pkg::PPVS_LOW;
      pins.secod <= ppvs_pkg::PPVS_LOW;
      if (op_reg == ppvs_pkg::PPVS_OP_VERIFY) begin
        if (state_reg inside {S_ARM, S_LATCH, S_REL, S_PULSE, S_LDROP})
          pins.secod <= ppvs_pkg::PPVS_HIGH;
        if (state_reg inside {S_LATCH, S_REL, S_PULSE})
          pins.latch <= ppvs_pkg::PPVS_HIGH;
      end else if (op_reg == ppvs_pkg::PPVS_OP_ERASE) begin
        if (follow_reg ? (state_reg inside {S_PULSE, S_RAMP})
                       : (state_reg inside {S_ARM, S_PULSE, S_RAMP, S_PLOW}))
          pins.latch <= ppvs_pkg::PPVS_HV2;
      end else if (op_reg == ppvs_pkg::PPVS_OP_SECURE) begin
        if (state_reg inside {S_LATCH, S_ARM, S_PULSE, S_RAMP, S_PLOW})
          pins.latch <= ppvs_pkg::PPVS_HIGH;
        if (follow_reg ? (state_reg inside {S_PULSE, S_RAMP})
                       : (state_reg inside {S_ARM, S_PULSE, S_RAMP, S_PLOW}))
          pins.secod <= ppvs_pkg::PPVS_HV2;
      end
    end
  end

  // status and read capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy       <= 1'b0;
      done       <= 1'b0;
      byte_valid <= 1'b0;
      byte_read  <= 8'h00;
      byte_match <= 1'b0;
      byte_group <= 4'h0;
      byte_line  <= 5'h00;
    end else begin
      busy       <= (state_reg != S_IDLE);
      done       <= (state_reg == S_END) && tick;
      byte_valid <= (state_reg == S_READ) && tick;
      if (state_reg == S_READ && tick) begin
        byte_read  <= din_s2_reg;
        byte_match <= (din_s2_reg == expected_byte);
        byte_group <= grp_code(grp_reg);
        byte_line  <= line_reg;
      end
    end
  end

  // helper for the width check: cycles the pulse pin has stood above low
  always_ff @(posedge clk) begin
    if (sys_rst || pins.pulse == ppvs_pkg::PPVS_LOW) begin
      hv_run_reg <= 24'h000000;
    end else if (hv_run_reg != 24'hFFFFFF) begin
      hv_run_reg <= hv_run_reg + 24'h000001;
    end
  end

  always_comb begin
    pulse_min = 24'(PULSE_CYCLES);
    if (op_reg == ppvs_pkg::PPVS_OP_VERIFY)
      pulse_min = 24'(VERIFY_CYCLES);
    else if (op_reg == ppvs_pkg::PPVS_OP_SECURE)
      pulse_min = 24'(SEC_CYCLES);
  end

  a_pulse_width_min: assert property (@(posedge clk) disable iff (sys_rst)
    pins.pulse == ppvs_pkg::PPVS_LOW && hv_run_reg != 24'h000000 |-> hv_run_reg >= pulse_min)
    else $error("pulse pin high for too short a time");
  a_verify_no_drive: assert property (@(posedge clk) disable iff (sys_rst)
    op_reg == ppvs_pkg::PPVS_OP_VERIFY && pins.pulse != ppvs_pkg::PPVS_LOW |-> !data_oe)
    else $error("data driven during verify pulse");
  a_enable_level: assert property (@(posedge clk) disable iff (sys_rst)
    busy && pins.pulse != ppvs_pkg::PPVS_LOW |-> pins.enable == ppvs_pkg::PPVS_HV1)
    else $error("enable not at level 1 during pulse");
  a_erase_latch: assert property (@(posedge clk) disable iff (sys_rst)
    op_reg == ppvs_pkg::PPVS_OP_ERASE && pins.pulse == ppvs_pkg::PPVS_HV3
    |-> pins.latch == ppvs_pkg::PPVS_HV2 && pins.tga == ppvs_pkg::TGA_ZERO)
    else $error("erase pulse without erase enable");
  a_sec_pin_level: assert property (@(posedge clk) disable iff (sys_rst)
    op_reg == ppvs_pkg::PPVS_OP_SECURE && pins.pulse != ppvs_pkg::PPVS_LOW
    |-> pins.secod == ppvs_pkg::PPVS_HV2 && pins.sel_a && pins.sel_b)
    else $error("security pulse without security level");
  a_sec_after_latch: assert property (@(posedge clk) disable iff (sys_rst)
    op_reg == ppvs_pkg::PPVS_OP_SECURE && $rose(pins.secod == ppvs_pkg::PPVS_HV2)
    |-> $past(pins.latch) == ppvs_pkg::PPVS_HIGH)
    else $error("security level raised before the address was latched");
  a_prog_line_ones: assert property (@(posedge clk) disable iff (sys_rst)
    op_reg == ppvs_pkg::PPVS_OP_PROG && data_oe |-> data_out == ppvs_pkg::LINE_ALL_ONES)
    else $error("program-all line address wrong");
  a_group_code: assert property (@(posedge clk) disable iff (sys_rst)
    byte_valid |-> byte_group >= ppvs_pkg::TGA_ZERO + 4'h1 && byte_group <= ppvs_pkg::TGA_SIG)
    else $error("group code out of range");
  a_ramp_follows: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pins.pulse == ppvs_pkg::PPVS_HV3) && op_reg != ppvs_pkg::PPVS_OP_VERIFY
    |-> pins.pulse == ppvs_pkg::PPVS_HV2) else $error("pulse not ramped to level 2");
  a_pins_steady: assert property (@(posedge clk) disable iff (sys_rst)
    busy && !tick && state_reg != S_IDLE && $stable(state_reg) |=> $stable(pins))
    else $error("pins moved between steps");

  c_verify_read:  cover property (@(posedge clk) disable iff (sys_rst) byte_valid && byte_match);
  c_erase_done:   cover property (@(posedge clk) disable iff (sys_rst)
    done && op_reg == ppvs_pkg::PPVS_OP_ERASE);
  c_secure_done:  cover property (@(posedge clk) disable iff (sys_rst)
    done && op_reg == ppvs_pkg::PPVS_OP_SECURE);
  c_prog_done:    cover property (@(posedge clk) disable iff (sys_rst)
    done && op_reg == ppvs_pkg::PPVS_OP_PROG);
endmodule

/* File: dv/ppvs_device_model.sv */
// Purpose: pin-level model of the programmable logic device in program/verify mode
// Assumes: fuse byte is a fixed function of latched group code and line address
// Notes:   released shared pins show the inverse of their last value, never a stale byte
`timescale 1ns/1ps

module ppvs_device_model (
  input  wire logic                 clk,
  input  wire ppvs_pkg::ppvs_pins_t pins,
  input  wire logic [7:0]           data_out,
  input  wire logic                 data_oe,
  output logic [7:0]                data_in,
  output logic [3:0]                latched_tga,
  output logic [7:0]                latched_line
);
  logic [7:0] last_bus = 8'h00;
  logic       latch_q  = 1'b0;
  logic       drive_en;

  initial latched_tga = 4'h0;
  initial latched_line = 8'h00;
  // device drives only once output-disable is low with the verify pulse up
  assign drive_en = !data_oe && pins.enable == ppvs_pkg::PPVS_HV1 && pins.sel_a && !pins.sel_b
    && pins.pulse == ppvs_pkg::PPVS_HV2 && pins.secod == ppvs_pkg::PPVS_LOW;
  assign data_in = data_oe ? data_out
    : drive_en ? ({latched_tga, 4'h0} ^ latched_line ^ 8'h3C) : ~last_bus;

  always @(posedge clk) begin
    last_bus <= data_in;
    latch_q  <= (pins.latch != ppvs_pkg::PPVS_LOW);
    if (pins.latch == ppvs_pkg::PPVS_HIGH && !latch_q) begin
      latched_tga  <= pins.tga;
      latched_line <= data_in;
    end
  end
endmodule

/* File: dv/ppvs_sequencer_tb.sv */
// Purpose: self-checking bench for the program/verify sequencer
// Assumes: shortened step and pulse counts; device model on the far side
// Notes:   pulse widths are judged in cycles against the counts set here
`timescale 1ns/1ps

module ppvs_sequencer_tb;
  localparam int unsigned PW = 5;
  localparam int unsigned SW = 9;
  localparam int unsigned VW = 4;
  logic                 clk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 start = 1'b0;
  ppvs_pkg::ppvs_op_t   op = ppvs_pkg::PPVS_OP_VERIFY;
  logic                 follow_pulse = 1'b0;
  logic [3:0]           verify_groups = 4'hA;
  logic [7:0]           expected_byte = 8'hBA;
  logic [7:0]           data_in, data_out, byte_read, lat_line;
  logic                 data_oe, busy, done, byte_valid, byte_match;
  logic [3:0]           byte_group, lat_tga;
  logic [4:0]           byte_line;
  ppvs_pkg::ppvs_pins_t pins;
  int                   n_errors = 0;
  int                   checks = 0;

  ppvs_sequencer #(.STEP_CYCLES(3), .PULSE_CYCLES(PW), .SEC_CYCLES(SW), .VERIFY_CYCLES(VW),
    .RAMP_CYCLES(3)) i_ppvs_sequencer (.clk(clk), .sys_rst(sys_rst), .start(start), .op(op),
    .follow_pulse(follow_pulse), .verify_groups(verify_groups), .expected_byte(expected_byte),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .pins(pins), .busy(busy),
    .done(done), .byte_valid(byte_valid), .byte_read(byte_read), .byte_match(byte_match),
    .byte_group(byte_group), .byte_line(byte_line));
  ppvs_device_model i_ppvs_device_model (.clk(clk), .pins(pins), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .latched_tga(lat_tga), .latched_line(lat_line));

  initial forever #10 clk = ~clk;

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one flow from start to done, watching the pins every cycle
  task automatic run_flow(input ppvs_pkg::ppvs_op_t o, input logic fol, input int min_hv);
    int n, run, min_run, bad, fbad, n_rd, g;
    logic fin, hv3, lat_any;
    logic [2:0] lat_rise, sec_rise;
    logic [3:0] code;
    logic [7:0] exp_d;
    n = 0; run = 0; min_run = 100000; bad = 0; fbad = 0; n_rd = 0;
    fin = 0; hv3 = 0; lat_any = 0; lat_rise = 0; sec_rise = 0;
    exp_d = (o == ppvs_pkg::PPVS_OP_PROG) ? 8'hFF : 8'h00;
    @(posedge clk);
    op <= o;
    follow_pulse <= fol;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    while (n < 40000 && !fin) begin
      @(posedge clk);
      #1;
      n++;
      if (pins.latch != ppvs_pkg::PPVS_LOW) lat_any = 1;
      if (pins.pulse != ppvs_pkg::PPVS_LOW) begin
        run++;
        if (run == 1) lat_rise = pins.latch;
        if (run == 1) sec_rise = pins.secod;
        if (pins.pulse == ppvs_pkg::PPVS_HV3) hv3 = 1;
        if (o != ppvs_pkg::PPVS_OP_VERIFY && (pins.tga !== 4'h0 || data_out !== exp_d
          || data_oe !== 1'b1 || pins.sel_a !== (o == ppvs_pkg::PPVS_OP_SECURE)
          || pins.sel_b !== 1'b1)) bad++;
        if (pins.enable != ppvs_pkg::PPVS_HV1) bad++;
      end else begin
        if (run > 0 && run < min_run) min_run = run;
        run = 0;
        if (fol && (o == ppvs_pkg::PPVS_OP_ERASE ? pins.latch : pins.secod) != 0) fbad++;
      end
      if (o == ppvs_pkg::PPVS_OP_VERIFY && (pins.sel_a !== 1'b1 || pins.sel_b !== 1'b0)) bad++;
      if (byte_valid === 1'b1) begin
        g = n_rd / 32;
        code = (g < 8) ? 4'(8 - g) : (g == 8 ? 4'h9 : 4'hA);
        exp_d = {code, 4'h0} ^ 8'(n_rd % 32) ^ 8'h3C;
        chk("latched group", code, lat_tga);
        chk("latched line", n_rd % 32, lat_line);
        chk("byte line", n_rd % 32, byte_line);
        chk("byte read", exp_d, byte_read);
        chk("byte match", exp_d == expected_byte, byte_match);
        n_rd++;
      end
      if (done === 1'b1) fin = 1;
    end
    if (!fin) begin
      chk("flow done", 1, 0);
      give_verdict();
    end
    chk("pulse width", 1, min_run >= min_hv);
    chk("pins during pulse", 0, bad);
    if (o == ppvs_pkg::PPVS_OP_VERIFY) chk("reads", 320, n_rd);
    else chk("hv3 step", 1, hv3);
    if (o == ppvs_pkg::PPVS_OP_PROG) chk("latch idle", 0, lat_any);
    if (o == ppvs_pkg::PPVS_OP_ERASE && !fol) chk("erase at rise", 3, lat_rise);
    if (o == ppvs_pkg::PPVS_OP_SECURE && !fol) chk("sec at rise", 3, sec_rise);
    if (o == ppvs_pkg::PPVS_OP_SECURE) chk("sec addr", 0, {lat_tga, lat_line});
    if (fol) chk("follow pulse", 0, fbad);
    repeat (2) @(posedge clk);
    #1;
    chk("enable off", ppvs_pkg::PPVS_LOW, pins.enable);
    chk("shared released", 0, {data_oe, busy});
  endtask

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // match twice: on group 0 line 5 and on group 8 (OE code) line 21
    expected_byte <= 8'h80 ^ 8'h05 ^ 8'h3C;
    run_flow(ppvs_pkg::PPVS_OP_VERIFY, 1'b0, VW);
    run_flow(ppvs_pkg::PPVS_OP_ERASE, 1'b0, PW);
    run_flow(ppvs_pkg::PPVS_OP_ERASE, 1'b1, PW);
    run_flow(ppvs_pkg::PPVS_OP_PROG, 1'b0, PW);
    run_flow(ppvs_pkg::PPVS_OP_SECURE, 1'b0, SW);
    run_flow(ppvs_pkg::PPVS_OP_SECURE, 1'b1, SW);
    give_verdict();
  end
endmodule
